/* File: dv/adc_channel_gain_sequencer_tb.sv */
// Self-checking bench joining the processor side and the converter control.
`timescale 1ns/1ps
module adc_channel_gain_sequencer_tb
    import adcseq_pkg::*;
;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic go = 1'b0;
    logic [7:0] cmd = 8'h00;
    logic use_irq = 1'b0;
    logic cmp_above = 1'b0;
    logic bipolar = 1'b0;
    logic host_busy;
    logic done;
    logic [11:0] result;
    logic [1:0] gain_sel;
    logic [1:0] conn_sel;
    logic [3:0] chan_sel;
    logic sample;
    logic [11:0] dac_code;
    logic [11:0] target = 12'h000;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    adcseq_if bus ();
    adcseq_dev i_adcseq_dev (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .bus(bus),
        .i_cmp_above(cmp_above), .i_bipolar(bipolar), .o_gain_sel(gain_sel),
        .o_conn_sel(conn_sel), .o_chan_sel(chan_sel), .o_sample(sample),
        .o_dac_code(dac_code));
    adcseq_host i_adcseq_host (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_go(go),
        .i_cmd(cmd), .i_use_irq(use_irq), .o_busy(host_busy), .o_done(done), .o_result(result),
        .bus(bus));
    adcseq_assertions i_adcseq_assertions (.i_core_clk(core_clk), .i_sys_rst(sys_rst),
        .port(bus.port), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .irq(bus.irq));
    always #2 core_clk = ~core_clk;
    // The input sits half a step above the target, so no trial code ever ties with it.
    always @(negedge core_clk)
        cmp_above <= {dac_code, 1'b0} < {target, 1'b1};
    always @(posedge core_clk)
    begin
        cycles++;
        // Six conversions of about 12500 cycles each, with margin.
        if (cycles == 90000)
        begin
            failures++;
            close_out();
        end
    end
    task automatic compare(input string what, input logic [11:0] exp, input logic [11:0] got);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic run_conv(input logic [7:0] c, input logic m, input logic [11:0] t,
        output int n);
        @(negedge core_clk);
        cmd = c;
        use_irq = m;
        target = t;
        go = 1'b1;
        @(negedge core_clk);
        go = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 20000)
        begin
            @(negedge core_clk);
            n++;
            if (n == 10)
            begin
                compare("gain", {10'h0, c[GAIN_MSB:GAIN_LSB]}, {10'h0, gain_sel});
                compare("conn", {10'h0, c[CONN_MSB:CONN_LSB]}, {10'h0, conn_sel});
                compare("chan", {8'h0, c[CHAN_MSB:CHAN_LSB]}, {8'h0, chan_sel});
                compare("sampling", 12'h1, {11'h0, sample});
                compare("host busy", 12'h1, {11'h0, host_busy});
            end
            if (n == SAMPLE_CYC - 10)
                compare("still sampling", 12'h1, {11'h0, sample});
            if (n == SAMPLE_CYC + 10)
                compare("holding", 12'h0, {11'h0, sample});
        end
        compare("rate", 12'h1, {11'h0, n <= 55 * CLK_MHZ});
        compare("host idle", 12'h0, {11'h0, host_busy});
    endtask
    task automatic s_poll();
        int n;
        run_conv({GAIN_X1, 2'h2, 4'hf}, 1'b0, 12'ha5c, n);
        compare("poll result", 12'ha5c, result);
        compare("irq after read", 12'h0, {11'h0, bus.irq});
    endtask
    task automatic s_irq();
        int n;
        run_conv({GAIN_X250, 2'h0, 4'h0}, 1'b1, 12'hfff, n);
        compare("irq result", 12'hfff, result);
    endtask
    task automatic s_gains();
        int n;
        run_conv({GAIN_X5, 2'h1, 4'h5}, 1'b0, 12'h000, n);
        compare("zero result", 12'h000, result);
        run_conv({GAIN_X50, 2'h3, 4'h8}, 1'b1, 12'h001, n);
        compare("lsb result", 12'h001, result);
    endtask
    // Bipolar codes: below mid-scale is negative, sign in bit 11, magnitude below.
    task automatic s_bipolar();
        int n;
        bipolar = 1'b1;
        run_conv({GAIN_X1, 2'h1, 4'h3}, 1'b0, 12'h7f0, n);
        compare("bipolar negative", 12'h810, result);
        run_conv({GAIN_X1, 2'h2, 4'hc}, 1'b1, 12'h9a3, n);
        compare("bipolar positive", 12'h1a3, result);
        bipolar = 1'b0;
    endtask
    initial
    begin
        repeat (10) @(negedge core_clk);
        sys_rst = 1'b0;
        s_poll();
        s_irq();
        s_gains();
        s_bipolar();
        close_out();
    end
endmodule

/* File: dv/adcseq_assertions.sv */
// Concurrent checks on the local bus between the processor side and the converter.
`timescale 1ns/1ps
module adcseq_assertions
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Bus signals
    input wire logic [1:0] port,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic irq
);
    localparam int CONV_LO = SAMPLE_CYC + SAR_BITS * BIT_CYC - 8;
    localparam int CONV_HI = CONV_MAX_US * CLK_MHZ;
    logic busy_q;
    logic busy_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic start;
    assign start = wr && port == PORT_CMD && !busy_q;
    // A start wins over a stale request so back-to-back runs are tracked.
    always_comb
    begin
        busy_d = start ? 1'b1 : (irq ? 1'b0 : busy_q);
        cnt_d = start ? 16'h1 : (busy_q ? cnt_q + 16'h1 : cnt_q);
    end
    always_ff @(posedge i_core_clk)
    begin
        busy_q <= i_sys_rst ? 1'b0 : busy_d;
        cnt_q <= i_sys_rst ? 16'h0 : cnt_d;
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    property p_wr_pulse; wr |=> !wr; endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
    property p_rd_hold; !rd |=> $stable(rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_hi_pad; rd && port == PORT_DATA_HI |=> rdata[7:4] == 4'h0; endproperty
    a_hi_pad: assert property (p_hi_pad) else $error("high byte padding");
    property p_conv_time;
        $rose(irq) |-> busy_q && cnt_q >= CONV_LO && cnt_q <= CONV_HI;
    endproperty
    a_conv_time: assert property (p_conv_time) else $error("conversion time");
    property p_start_clr; start |=> !irq; endproperty
    a_start_clr: assert property (p_start_clr) else $error("irq kept on start");
    property p_irq_hold; irq && !rd && !wr |=> irq; endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
    property p_irq_read;
        irq && rd && (port == PORT_DATA_LO || port == PORT_DATA_HI) |=> !irq;
    endproperty
    a_irq_read: assert property (p_irq_read) else $error("irq not cleared");
    property p_stat_busy;
        rd && port == PORT_STATUS && busy_q && !irq |=> rdata == 8'h02;
    endproperty
    a_stat_busy: assert property (p_stat_busy) else $error("busy status");
    property p_stat_done; rd && port == PORT_STATUS && irq |=> rdata == 8'h01; endproperty
    a_stat_done: assert property (p_stat_done) else $error("done status");
    c_irq: cover property ($rose(irq));
    c_stat: cover property (rd && port == PORT_STATUS && irq);
    c_hi: cover property (rd && port == PORT_DATA_HI);
endmodule

/* File: src/adcseq_dev.sv */
// Converter control: command latch, sample/hold and SAR sequencing, result ports.
`timescale 1ns/1ps
module adcseq_dev
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // Local bus
    adcseq_if.dev bus,
    // Analog front end
    input wire logic i_cmp_above,
    input wire logic i_bipolar,
    output logic [1:0] o_gain_sel,
    output logic [1:0] o_conn_sel,
    output logic [3:0] o_chan_sel,
    output logic o_sample,
    output logic [11:0] o_dac_code
);
    typedef enum logic [1:0] {S_IDLE, S_SAMPLE, S_CONV} adcseq_state_e;

    adcseq_state_e state_q, state_d;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0] bit_q, bit_d;
    logic [11:0] sar_q, sar_d;
    logic [11:0] res_q, res_d;
    logic [7:0] cmd_q, cmd_d;
    logic eoc_q, eoc_d;
    logic irq_q, irq_d;
    logic [7:0] rdata_q, rdata_d;
    logic start;

    assign start = bus.wr && bus.port == PORT_CMD && state_q == S_IDLE;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        bit_d = bit_q;
        sar_d = sar_q;
        res_d = res_q;
        cmd_d = cmd_q;
        eoc_d = eoc_q;
        irq_d = irq_q;
        rdata_d = rdata_q;
        unique case (state_q)
            S_IDLE:
            begin
                if (start)
                begin
                    cmd_d = bus.wdata;
                    state_d = S_SAMPLE;
                    cnt_d = SAMPLE_CNT;
                    eoc_d = 1'b0;
                    irq_d = 1'b0;
                end
            end
            S_SAMPLE:
            begin
                if (cnt_q == 16'h0)
                begin
                    state_d = S_CONV;
                    cnt_d = BIT_CNT;
                    bit_d = 4'(SAR_BITS - 1);
                    sar_d = 12'h800;
                end
                else
                begin
                    cnt_d = cnt_q - 16'h1;
                end
            end
            S_CONV:
            begin
                if (cnt_q != 16'h0)
                begin
                    cnt_d = cnt_q - 16'h1;
                end
                else
                begin
                    // Keep the trial bit when the input stays above the DAC code.
                    if (!i_cmp_above)
                    begin
                        sar_d[bit_q] = 1'b0;
                    end
                    if (bit_q == 4'h0)
                    begin
                        state_d = S_IDLE;
                        // Offset binary to sign plus magnitude in bipolar mode.
                        if (i_bipolar)
                        begin
                            res_d = sar_d[11] ? {1'b0, sar_d[10:0]} : {1'b1, 11'(12'h800 - sar_d)};
                        end
                        else
                        begin
                            res_d = sar_d;
                        end
                        eoc_d = 1'b1;
                        irq_d = 1'b1;
                    end
                    else
                    begin
                        sar_d[bit_q - 4'h1] = 1'b1;
                        bit_d = bit_q - 4'h1;
                        cnt_d = BIT_CNT;
                    end
                end
            end
            // The fourth state code is unused; fall back to idle if it ever appears.
            default:
            begin
                state_d = S_IDLE;
            end
        endcase
        if (bus.rd)
        begin
            unique case (bus.port)
                PORT_DATA_LO: rdata_d = res_q[7:0];
                PORT_DATA_HI: rdata_d = {4'h0, res_q[11:8]};
                PORT_STATUS: rdata_d = {6'h0, state_q != S_IDLE, eoc_q};
                PORT_CMD: rdata_d = 8'h0;
            endcase
            // A set in this cycle wins over the read clear.
            if ((bus.port == PORT_DATA_LO || bus.port == PORT_DATA_HI) && !(irq_d && !irq_q))
            begin
                irq_d = 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            state_q <= S_IDLE;
            cnt_q <= 16'h0;
            bit_q <= 4'h0;
            sar_q <= 12'h0;
            res_q <= 12'h0;
            cmd_q <= 8'h0;
            eoc_q <= 1'b0;
            irq_q <= 1'b0;
            rdata_q <= 8'h0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sar_q <= sar_d;
            res_q <= res_d;
            cmd_q <= cmd_d;
            eoc_q <= eoc_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // Sample only in the sampling phase; hold during trials and idle.
    logic sample_q;
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            sample_q <= 1'b0;
        end
        else
        begin
            sample_q <= state_d == S_SAMPLE;
        end
    end

    assign o_sample = sample_q;
    assign o_gain_sel = cmd_q[GAIN_MSB:GAIN_LSB];
    assign o_conn_sel = cmd_q[CONN_MSB:CONN_LSB];
    assign o_chan_sel = cmd_q[CHAN_MSB:CHAN_LSB];
    assign o_dac_code = sar_q;
    assign bus.rdata = rdata_q;
    assign bus.irq = irq_q;
endmodule

/* File: src/adcseq_host.sv */
// Processor-side bus master: issues a command, waits for completion, reads both bytes.
`timescale 1ns/1ps
module adcseq_host
    import adcseq_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    // User request
    input wire logic i_go,
    input wire logic [7:0] i_cmd,
    input wire logic i_use_irq,
    output logic o_busy,
    output logic o_done,
    output logic [11:0] o_result,
    // Local bus
    adcseq_if.host bus
);
    typedef enum logic [2:0] {H_IDLE, H_WAIT, H_POLL, H_RDLO, H_RDHI, H_DONE} adcseq_hstate_e;

    adcseq_hstate_e st_q, st_d;
    logic [1:0] port_q, port_d;
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic [7:0] wdata_q, wdata_d;
    logic [11:0] res_q, res_d;
    logic done_q, done_d;
    logic mode_q, mode_d;
    logic pend_q, pend_d;

    always_comb
    begin
        st_d = st_q;
        port_d = port_q;
        wr_d = 1'b0;
        rd_d = 1'b0;
        wdata_d = wdata_q;
        res_d = res_q;
        done_d = 1'b0;
        mode_d = mode_q;
        pend_d = 1'b0;
        unique case (st_q)
            H_IDLE:
            begin
                if (i_go)
                begin
                    port_d = PORT_CMD;
                    wdata_d = i_cmd;
                    wr_d = 1'b1;
                    mode_d = i_use_irq;
                    st_d = H_WAIT;
                end
            end
            H_WAIT:
            begin
                // Interrupt mode watches the request; poll mode reads status.
                if (mode_q && bus.irq)
                begin
                    port_d = PORT_DATA_LO;
                    rd_d = 1'b1;
                    st_d = H_RDLO;
                end
                else if (!mode_q && !pend_q)
                begin
                    port_d = PORT_STATUS;
                    rd_d = 1'b1;
                    st_d = H_POLL;
                end
            end
            H_POLL:
            begin
                pend_d = 1'b1;
                st_d = H_WAIT;
                if (!rd_q && bus.rdata[STAT_EOC_BIT])
                begin
                    port_d = PORT_DATA_LO;
                    rd_d = 1'b1;
                    st_d = H_RDLO;
                end
                else if (rd_q)
                begin
                    st_d = H_POLL;
                end
            end
            H_RDLO:
            begin
                if (!rd_q)
                begin
                    res_d[7:0] = bus.rdata;
                    port_d = PORT_DATA_HI;
                    rd_d = 1'b1;
                    st_d = H_RDHI;
                end
            end
            H_RDHI:
            begin
                if (!rd_q)
                begin
                    res_d[11:8] = bus.rdata[3:0];
                    st_d = H_DONE;
                end
            end
            H_DONE:
            begin
                done_d = 1'b1;
                st_d = H_IDLE;
            end
            default:
            begin
                st_d = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            st_q <= H_IDLE;
            port_q <= PORT_CMD;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wdata_q <= 8'h0;
            res_q <= 12'h0;
            done_q <= 1'b0;
            mode_q <= 1'b0;
            pend_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            port_q <= port_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            wdata_q <= wdata_d;
            res_q <= res_d;
            done_q <= done_d;
            mode_q <= mode_d;
            pend_q <= pend_d;
        end
    end

    logic busy_q;
    always_ff @(posedge i_core_clk)
    begin
        if (i_sys_rst)
        begin
            busy_q <= 1'b0;
        end
        else
        begin
            busy_q <= st_d != H_IDLE;
        end
    end

    assign bus.port = port_q;
    assign bus.wr = wr_q;
    assign bus.rd = rd_q;
    assign bus.wdata = wdata_q;
    assign o_busy = busy_q;
    assign o_done = done_q;
    assign o_result = res_q;
endmodule

/* File: src/adcseq_if.sv */
// Local I/O bus between the processor side and the converter control.
`timescale 1ns/1ps
interface adcseq_if;
    logic [1:0] port;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic irq;
    modport dev (input port, input wr, input rd, input wdata, output rdata, output irq);
    modport host (output port, output wr, output rd, output wdata, input rdata, input irq);
endinterface

/* File: src/adcseq_pkg.sv */
// Shared constants for the analog input sequencer and its local-bus master.
package adcseq_pkg;
    localparam int CLK_MHZ = 250;
    localparam int SAMPLE_US = 15;
    localparam int CONV_MAX_US = 50;
    localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
    localparam int SAR_BITS = 12;
    // Conversion budget left after sampling, spread over the 12 bit trials.
    localparam int BIT_CYC = ((CONV_MAX_US - SAMPLE_US) * CLK_MHZ) / SAR_BITS;
    localparam logic [15:0] SAMPLE_CNT = 16'(SAMPLE_CYC - 1);
    localparam logic [15:0] BIT_CNT = 16'(BIT_CYC - 1);
    // Port selections on the local I/O bus.
    localparam logic [1:0] PORT_CMD = 2'h0;
    localparam logic [1:0] PORT_DATA_LO = 2'h1;
    localparam logic [1:0] PORT_DATA_HI = 2'h2;
    localparam logic [1:0] PORT_STATUS = 2'h3;
    // Command and status byte fields.
    localparam int GAIN_MSB = 7;
    localparam int GAIN_LSB = 6;
    localparam int CONN_MSB = 5;
    localparam int CONN_LSB = 4;
    localparam int CHAN_MSB = 3;
    localparam int CHAN_LSB = 0;
    localparam int STAT_EOC_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X5 = 2'h1;
    localparam logic [1:0] GAIN_X50 = 2'h2;
    localparam logic [1:0] GAIN_X250 = 2'h3;
endpackage
